/* File: verilog/rtcwin_regs.vh */
`ifndef RTCWIN_REGS_VH
`define RTCWIN_REGS_VH

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RTCWIN_PTR_HI 9
`define RTCWIN_PTR_LO 8
`define RTCWIN_WREN_BIT 13
`define RTCWIN_ON_BIT 15

// ------------------------------------------------------------
// Pointer codes
// ------------------------------------------------------------
`define RTCWIN_PTR_MINSEC 2'h0
`define RTCWIN_PTR_WDHR 2'h1
`define RTCWIN_PTR_MTHDAY 2'h2
`define RTCWIN_PTR_YEAR 2'h3

// ------------------------------------------------------------
// Unlock key values and window length
// ------------------------------------------------------------
`define RTCWIN_KEY_FIRST 8'h55
`define RTCWIN_KEY_SECOND 8'hAA
`define RTCWIN_UNLOCK_CYCLES 2'h1

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RTCWIN_CFG_RESET 16'h0000
`define RTCWIN_ALM_RESET 16'h0000
`define RTCWIN_BYTE_RESET 8'h00

`endif

/* File: verilog/rtcwin_access.v */
// Summary of operation
// - Value pointer at config bits 9:8 selects the timekeeping register pair.
// - Value-window high-byte write decrements pointer, holding at 00.
// - Value pointer 00 min/sec, 01 weekday/hours, 10 month/day, 11 year.
// - Alarm pointer at alarm config bits 9:8 selects the alarm pair.
// - Alarm-window high-byte write decrements alarm pointer, holding at 00.
// - Alarm pointer 00 min/sec, 01 weekday/hours, 10 month/day, 11 none.
// - Any read of either alarm window byte decrements the alarm pointer.
// - Any read of either value window byte decrements the value pointer.
// - Timekeeping writes only take effect while write-enable bit 13 is set.
// - Write-enable may be set only one cycle after 55h then AAh key writes.
// - Year register writes accepted only while write-enable is 1.
// - Module-on bit writes accepted only while write-enable is 1.
`timescale 1ns/1ns
`default_nettype none
`include "rtcwin_regs.vh"

module rtcwin_access #(
    parameter DW = 16
) (
    input wire clk_in,
    input wire rst_in,
    input wire cfg_wr_in,
    input wire [DW-1:0] cfg_wdata_in,
    input wire alm_cfg_wr_in,
    input wire [DW-1:0] alm_cfg_wdata_in,
    input wire key_wr_in,
    input wire [7:0] key_wdata_in,
    input wire val_wr_hi_in,
    input wire val_wr_lo_in,
    input wire val_rd_in,
    input wire [DW-1:0] val_wdata_in,
    input wire alm_wr_hi_in,
    input wire alm_wr_lo_in,
    input wire alm_rd_in,
    input wire [DW-1:0] alm_wdata_in,
    output reg [DW-1:0] cfg_rdata_out,
    output reg [DW-1:0] alm_cfg_rdata_out,
    output reg [DW-1:0] val_rdata_out,
    output reg [DW-1:0] alm_rdata_out,
    output reg timer_write_enable_out,
    output reg clock_module_on_out
);

// ------------------------------------------------------------
// State
// ------------------------------------------------------------
reg [DW-1:0] clock_config_calibration_reg;
reg [DW-1:0] alarm_config_repeat_reg;
reg [7:0] tk_reg [0:7];
reg [7:0] al_reg [0:5];
reg [1:0] key_state_reg;
reg [1:0] unlock_cnt_reg;
wire [1:0] value_window_pointer;
wire [1:0] alarm_window_pointer;
wire timer_write_enable;
wire unlocked;
wire val_step;
wire alm_step;
wire [1:0] vp_next;
wire [1:0] ap_next;
wire [DW-1:0] val_mux;
wire [DW-1:0] alm_mux;
integer i;

assign value_window_pointer = clock_config_calibration_reg[`RTCWIN_PTR_HI:`RTCWIN_PTR_LO];
assign alarm_window_pointer = alarm_config_repeat_reg[`RTCWIN_PTR_HI:`RTCWIN_PTR_LO];
assign timer_write_enable = clock_config_calibration_reg[`RTCWIN_WREN_BIT];
assign unlocked = (unlock_cnt_reg != 2'h0);

// ------------------------------------------------------------
// Pointer stepping
// ------------------------------------------------------------
assign val_step = val_wr_hi_in | val_rd_in;
assign alm_step = alm_wr_hi_in | alm_rd_in;
assign vp_next = (value_window_pointer == `RTCWIN_PTR_MINSEC) ? `RTCWIN_PTR_MINSEC :
                 value_window_pointer - 2'h1;
assign ap_next = (alarm_window_pointer == `RTCWIN_PTR_MINSEC) ? `RTCWIN_PTR_MINSEC :
                 alarm_window_pointer - 2'h1;

// ------------------------------------------------------------
// Window decode (pair index = pointer, high byte at 2p+1)
// ------------------------------------------------------------
assign val_mux = (value_window_pointer == `RTCWIN_PTR_YEAR) ?
                 {8'h00, tk_reg[6]} :
                 {tk_reg[{value_window_pointer, 1'b1}], tk_reg[{value_window_pointer, 1'b0}]};
assign alm_mux = (alarm_window_pointer == `RTCWIN_PTR_YEAR) ? 16'h0000 :
                 {al_reg[{alarm_window_pointer, 1'b1}], al_reg[{alarm_window_pointer, 1'b0}]};

// ------------------------------------------------------------
// Unlock sequence: 55h then AAh opens a one-cycle window
// ------------------------------------------------------------
always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
        key_state_reg <= 2'h0;
        unlock_cnt_reg <= 2'h0;
    end else begin
        if (unlock_cnt_reg != 2'h0)
            unlock_cnt_reg <= unlock_cnt_reg - 2'h1;
        if (key_wr_in) begin
            if (key_state_reg == 2'h1 && key_wdata_in == `RTCWIN_KEY_SECOND) begin
                key_state_reg <= 2'h0;
                unlock_cnt_reg <= `RTCWIN_UNLOCK_CYCLES;
            end else if (key_wdata_in == `RTCWIN_KEY_FIRST) begin
                key_state_reg <= 2'h1;
            end else begin
                key_state_reg <= 2'h0;
            end
        end else if (cfg_wr_in) begin
            key_state_reg <= 2'h0;
        end
    end
end

// ------------------------------------------------------------
// Configuration registers
// ------------------------------------------------------------
always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
        clock_config_calibration_reg <= `RTCWIN_CFG_RESET;
        alarm_config_repeat_reg <= `RTCWIN_ALM_RESET;
    end else begin
        if (cfg_wr_in) begin
            clock_config_calibration_reg <= cfg_wdata_in;
            // Setting write-enable only inside unlock window; clearing any time
            if (cfg_wdata_in[`RTCWIN_WREN_BIT] && !timer_write_enable && !unlocked)
                clock_config_calibration_reg[`RTCWIN_WREN_BIT] <= 1'b0;
            if (!timer_write_enable)
                clock_config_calibration_reg[`RTCWIN_ON_BIT] <=
                    clock_config_calibration_reg[`RTCWIN_ON_BIT];
        end else if (val_step) begin
            clock_config_calibration_reg[`RTCWIN_PTR_HI:`RTCWIN_PTR_LO] <= vp_next;
        end
        if (alm_cfg_wr_in)
            alarm_config_repeat_reg <= alm_cfg_wdata_in;
        else if (alm_step)
            alarm_config_repeat_reg[`RTCWIN_PTR_HI:`RTCWIN_PTR_LO] <= ap_next;
    end
end

// ------------------------------------------------------------
// Timekeeping and alarm byte storage
// ------------------------------------------------------------
always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
        for (i = 0; i < 8; i = i + 1)
            tk_reg[i] <= `RTCWIN_BYTE_RESET;
        for (i = 0; i < 6; i = i + 1)
            al_reg[i] <= `RTCWIN_BYTE_RESET;
    end else begin
        if (timer_write_enable) begin
            if (val_wr_hi_in && value_window_pointer != `RTCWIN_PTR_YEAR)
                tk_reg[{value_window_pointer, 1'b1}] <= val_wdata_in[15:8];
            if (val_wr_lo_in)
                tk_reg[{value_window_pointer, 1'b0}] <= val_wdata_in[7:0];
        end
        if (alarm_window_pointer != `RTCWIN_PTR_YEAR) begin
            if (alm_wr_hi_in)
                al_reg[{alarm_window_pointer, 1'b1}] <= alm_wdata_in[15:8];
            if (alm_wr_lo_in)
                al_reg[{alarm_window_pointer, 1'b0}] <= alm_wdata_in[7:0];
        end
    end
end

// ------------------------------------------------------------
// Registered outputs
// ------------------------------------------------------------
always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
        cfg_rdata_out <= `RTCWIN_CFG_RESET;
        alm_cfg_rdata_out <= `RTCWIN_ALM_RESET;
        val_rdata_out <= 16'h0000;
        alm_rdata_out <= 16'h0000;
        timer_write_enable_out <= 1'b0;
        clock_module_on_out <= 1'b0;
    end else begin
        cfg_rdata_out <= clock_config_calibration_reg;
        alm_cfg_rdata_out <= alarm_config_repeat_reg;
        val_rdata_out <= val_mux;
        alm_rdata_out <= alm_mux;
        timer_write_enable_out <= timer_write_enable;
        clock_module_on_out <= clock_config_calibration_reg[`RTCWIN_ON_BIT];
    end
end

endmodule // rtcwin_access
`default_nettype wire

/* File: verification/rtcwin_access_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module rtcwin_access_asserts (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cfg_wr_in,
    input wire logic [15:0] cfg_wdata_in,
    input wire logic alm_cfg_wr_in,
    input wire logic [15:0] alm_cfg_wdata_in,
    input wire logic key_wr_in,
    input wire logic [7:0] key_wdata_in,
    input wire logic val_wr_hi_in,
    input wire logic val_rd_in,
    input wire logic alm_wr_hi_in,
    input wire logic alm_rd_in,
    input wire logic [15:0] cfg_rdata_out,
    input wire logic [15:0] alm_cfg_rdata_out,
    input wire logic timer_write_enable_out,
    input wire logic clock_module_on_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ----
    // Pointer steps down and holds at zero
    // ----
    function automatic logic [1:0] dn(input logic [1:0] p);
        return (p == 2'h0) ? p : p - 2'h1;
    endfunction
    sequence unlock_seq;
        key_wr_in && key_wdata_in == 8'h55 ##1 key_wr_in && key_wdata_in == 8'hAA
        ##1 cfg_wr_in && cfg_wdata_in[13];
    endsequence
    chk_val_rd_step: assert property (val_rd_in && !val_wr_hi_in && !cfg_wr_in
        |=> ##1 cfg_rdata_out[9:8] == dn($past(cfg_rdata_out[9:8]))) else $error("val rd step");
    chk_val_hi_step: assert property (val_wr_hi_in && !val_rd_in && !cfg_wr_in
        |=> ##1 cfg_rdata_out[9:8] == dn($past(cfg_rdata_out[9:8]))) else $error("val wr step");
    chk_alm_rd_step: assert property (alm_rd_in && !alm_wr_hi_in && !alm_cfg_wr_in
        |=> ##1 alm_cfg_rdata_out[9:8] == dn($past(alm_cfg_rdata_out[9:8]))) else $error("alm rd");
    chk_alm_hi_step: assert property (alm_wr_hi_in && !alm_rd_in && !alm_cfg_wr_in
        |=> ##1 alm_cfg_rdata_out[9:8] == dn($past(alm_cfg_rdata_out[9:8]))) else $error("alm wr");
    chk_cfg_ptr_load: assert property (cfg_wr_in
        |=> ##1 cfg_rdata_out[9:8] == $past(cfg_wdata_in[9:8], 2)) else $error("cfg ptr");
    chk_alm_ptr_load: assert property (alm_cfg_wr_in
        |=> ##1 alm_cfg_rdata_out[9:8] == $past(alm_cfg_wdata_in[9:8], 2)) else $error("alm ptr");
    chk_wren_unlock: assert property (unlock_seq |=> ##1 timer_write_enable_out)
        else $error("wren not set");
    chk_wren_cause: assert property ($rose(timer_write_enable_out)
        |-> $past(cfg_wr_in && cfg_wdata_in[13], 2) && $past(key_wr_in && key_wdata_in == 8'hAA, 3))
        else $error("wren set outside window");
    chk_on_locked: assert property (cfg_wr_in && !$past(cfg_wr_in) && !timer_write_enable_out
        |=> ##1 clock_module_on_out == $past(clock_module_on_out, 2)) else $error("on bit locked");
endmodule // rtcwin_access_asserts
bind rtcwin_access rtcwin_access_asserts u_chk (.clk_in, .rst_in, .cfg_wr_in, .cfg_wdata_in,
    .alm_cfg_wr_in, .alm_cfg_wdata_in, .key_wr_in, .key_wdata_in, .val_wr_hi_in, .val_rd_in,
    .alm_wr_hi_in, .alm_rd_in, .cfg_rdata_out, .alm_cfg_rdata_out, .timer_write_enable_out,
    .clock_module_on_out);
`default_nettype wire

/* File: verification/rtcwin_access_test.sv */
`timescale 1ns/1ns
`default_nettype none
module rtcwin_access_test;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [8:0] s = 9'h000;
    logic [15:0] d = 16'h0000;
    logic [15:0] cfg_rdata_out, alm_cfg_rdata_out, val_rdata_out, alm_rdata_out;
    logic timer_write_enable_out, clock_module_on_out;
    int n_mismatch = 0;
    int compares = 0;
    always #5 clk_in = ~clk_in;
    rtcwin_access u_rtcwin_access (.clk_in, .rst_in, .cfg_wr_in(s[0]), .cfg_wdata_in(d),
        .alm_cfg_wr_in(s[1]), .alm_cfg_wdata_in(d), .key_wr_in(s[2]), .key_wdata_in(d[7:0]),
        .val_wr_hi_in(s[3]), .val_wr_lo_in(s[4]), .val_rd_in(s[5]), .val_wdata_in(d),
        .alm_wr_hi_in(s[6]), .alm_wr_lo_in(s[7]), .alm_rd_in(s[8]), .alm_wdata_in(d),
        .cfg_rdata_out, .alm_cfg_rdata_out, .val_rdata_out, .alm_rdata_out,
        .timer_write_enable_out, .clock_module_on_out);
    // ----
    // Strobe bits: cfg, alm cfg, key, val hi, val lo, val rd, alm hi, alm lo, alm rd
    // ----
    task op(input logic [8:0] m, input logic [15:0] v);
        s <= m;
        d <= v;
        @(posedge clk_in);
    endtask
    task idle(input int n);
        s <= 9'h000;
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task tally_and_finish;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task walk(input bit a, input logic [15:0] top);
        logic [15:0] e [5];
        e = '{top, 16'h1231, 16'h0523, 16'h5930, 16'h5930};
        op(9'h004, 16'h0055);
        op(9'h004, 16'h00AA);
        op(a ? 9'h002 : 9'h001, 16'hA300);
        for (int i = 0; i < 4; i++) op(a ? 9'h0C0 : 9'h018, i ? e[i] : 16'h0019);
        idle(2);
        chk("config", a ? 16'h0000 : 16'hA000, a ? alm_cfg_rdata_out & 16'h0300 : cfg_rdata_out);
        op(a ? 9'h002 : 9'h001, 16'hA300);
        idle(2);
        for (int i = 0; i < 5; i++) begin
            chk("window", e[i], a ? alm_rdata_out : val_rdata_out);
            op(a ? 9'h100 : 9'h020, 16'h0000);
            idle(2);
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        idle(1);
        chk("config", 16'h0000, cfg_rdata_out);
        op(9'h004, 16'h0055);
        idle(1);
        op(9'h004, 16'h00AA);
        op(9'h001, 16'hA300);
        op(9'h018, 16'h1142);
        idle(2);
        chk("config", 16'h2200, cfg_rdata_out);
        chk("wren", 16'h0001, {15'h0000, timer_write_enable_out});
        chk("module on", 16'h0000, {15'h0000, clock_module_on_out});
        walk(1'b0, 16'h0019);
        chk("module on", 16'h0001, {15'h0000, clock_module_on_out});
        walk(1'b1, 16'h0000);
        op(9'h001, 16'h0300);
        op(9'h010, 16'h0077);
        idle(2);
        chk("year", 16'h0019, val_rdata_out);
        chk("wren", 16'h0000, {15'h0000, timer_write_enable_out});
        chk("module on", 16'h0000, {15'h0000, clock_module_on_out});
        tally_and_finish;
    end
    initial begin
        #20000;
        n_mismatch++;
        tally_and_finish;
    end
endmodule // rtcwin_access_test
`default_nettype wire
